// *** common/adcoc_pkg.sv ***
// constants, register map and encodings for the converter output control
// assumes a 100 MHz clk_i that is twice the device input clock
package adcoc_pkg;
    // -------------------------------------------------------------
    // clock and timing
    // -------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int CLK_PERIOD_NS    = 1000 / CLK_MHZ;
    localparam int IN_CLK_MHZ       = CLK_MHZ / 2;
    localparam int RETIMER_MIN_MHZ  = 40;
    localparam int RELOCK_MIN_NS    = 1500;
    localparam int RELOCK_MAX_NS    = 5000;
    localparam int RELOCK_CYC       =
        (RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_W           = 8;
    localparam int LATENCY          = 10;
    localparam int DIV_MAX          = 8;

    // -------------------------------------------------------------
    // register indices (byte address is four times the index)
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_CHAN_SEL    = 8'h05;
    localparam logic [7:0] IDX_POWER_MODE  = 8'h08;
    localparam logic [7:0] IDX_CLOCK_CTRL  = 8'h09;
    localparam logic [7:0] IDX_CLOCK_DIV   = 8'h0b;
    localparam logic [7:0] IDX_OUTPUT_MODE = 8'h14;
    localparam logic [7:0] IDX_DRIVE_CTRL  = 8'h15;
    localparam logic [7:0] IDX_SYNC_CTRL   = 8'h3a;
    localparam logic [7:0] IDX_STATUS      = 8'h40;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int OM_DISABLE_BIT   = 4;
    localparam int OM_SPARE_BIT     = 2;
    localparam int SYNC_EN_BIT      = 1;
    localparam int SYNC_ONCE_BIT    = 2;
    localparam logic [1:0] CHAN_SEL_RST    = 2'h3;
    localparam logic [1:0] FMT_RST         = 2'h1;
    localparam logic       OM_SPARE_RST    = 1'b1;
    localparam logic       RETIMER_EN_RST  = 1'b1;
    localparam logic [2:0] DIV_M1_RST      = 3'h0;

    // output sample encodings
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS   = 2'h1;
    localparam logic [1:0] FMT_GRAY   = 2'h2;

    // power modes
    localparam logic [1:0] PM_NORMAL  = 2'h0;
    localparam logic [1:0] PM_DOWN    = 2'h1;
    localparam logic [1:0] PM_STANDBY = 2'h2;

    // sample limits
    localparam int IN_W  = 14;
    localparam int OUT_W = 12;
    localparam logic signed [IN_W-1:0] FS_POS = 14'sh07ff;
    localparam logic signed [IN_W-1:0] FS_NEG = -14'sh0800;
    localparam logic [OUT_W-1:0] MSB_FLIP = 12'h800;
endpackage

// *** hdl/adcoc_top.sv ***
// output, power, retiming and sync control of a dual converter
// assumes samples on clk_i and a classic wishbone master on the same clock
`timescale 1ns/1ps
module adcoc_top (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [9:0]                     wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic signed [adcoc_pkg::IN_W-1:0] ch_a_sample_i,
    input  wire logic signed [adcoc_pkg::IN_W-1:0] ch_b_sample_i,
    input  wire logic                           power_down_pin_i,
    input  wire logic                           output_three_state_pin_i,
    input  wire logic                           sync_i,
    output logic      [adcoc_pkg::OUT_W-1:0]    data_o,
    output logic                                data_oe_o,
    output logic                                overrange_o,
    output logic                                capture_clock_out_o,
    output logic                                reduced_drive_o,
    output logic                                power_down_o,
    output logic                                standby_o,
    output logic                                ref_powered_o,
    output logic                                retimer_active_o
);
    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    typedef logic [adcoc_pkg::OUT_W:0] adcoc_word_t;

    typedef struct packed {
        logic                                   ack;
        logic [31:0]                            rdata;
        logic [1:0]                             chan_sel;
        logic [1:0]                             pmode;
        logic                                   retimer_en;
        logic                                   reduced_drive;
        logic [2:0]                             div_m1;
        logic [1:0]                             fmt;
        logic                                   om_spare;
        logic [1:0]                             dis;
        logic                                   sync_en;
        logic                                   sync_once;
        logic                                   sync_armed;
        logic [2:0]                             s_sync;
        logic [1:0]                             s_pd;
        logic [1:0]                             s_oeb;
        logic [3:0]                             cnt;
        logic [adcoc_pkg::LOCK_W-1:0]           lock_cnt;
        logic                                   active;
        logic [adcoc_pkg::LATENCY-1:0][adcoc_pkg::OUT_W:0] pipe_a;
        logic [adcoc_pkg::LATENCY-1:0][adcoc_pkg::OUT_W:0] pipe_b;
        logic [adcoc_pkg::OUT_W:0]              held_b;
        logic [adcoc_pkg::OUT_W-1:0]            data;
        logic                                   ovr;
        logic                                   oe;
        logic                                   cclk;
        logic                                   pd;
        logic                                   stby;
        logic                                   refp;
    } adcoc_state_t;

    adcoc_state_t st_reg;
    adcoc_state_t st_next;

    // -------------------------------------------------------------
    // functions
    // -------------------------------------------------------------
    // clamp to twelve bits; top bit of result is the overrange flag
    function automatic adcoc_word_t clamp_s(
        input logic signed [adcoc_pkg::IN_W-1:0] v);
        adcoc_word_t w;
        if (v > adcoc_pkg::FS_POS) begin
            w = {1'b1, adcoc_pkg::FS_POS[adcoc_pkg::OUT_W-1:0]};
        end else if (v < adcoc_pkg::FS_NEG) begin
            w = {1'b1, adcoc_pkg::FS_NEG[adcoc_pkg::OUT_W-1:0]};
        end else begin
            w = {1'b0, v[adcoc_pkg::OUT_W-1:0]};
        end
        return w;
    endfunction

    function automatic logic [adcoc_pkg::OUT_W-1:0] encode(
        input logic [adcoc_pkg::OUT_W-1:0] twos,
        input logic [1:0] fmt);
        logic [adcoc_pkg::OUT_W-1:0] ob;
        ob = twos ^ adcoc_pkg::MSB_FLIP;
        unique case (fmt)
            adcoc_pkg::FMT_OFFSET: encode = ob;
            adcoc_pkg::FMT_GRAY:   encode = ob ^ (ob >> 1);
            default:               encode = twos;
        endcase
    endfunction

    // divided input rate below the retimer floor
    function automatic logic rate_low(input logic [2:0] div_m1);
        rate_low = (({1'b0, div_m1} + 4'h1) * adcoc_pkg::RETIMER_MIN_MHZ)
                   > adcoc_pkg::IN_CLK_MHZ;
    endfunction

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    logic       acc;
    logic       wr;
    logic [7:0] idx;
    logic [3:0] ratio;
    logic [3:0] period_m1;
    logic [3:0] hi;
    logic       sync_hit;
    logic       tick;
    logic       pd_now;

    always_comb begin
        st_next   = st_reg;
        acc       = wb_cyc_i && wb_stb_i && !st_reg.ack;
        wr        = acc && wb_we_i && wb_sel_i[0];
        idx       = wb_adr_i[9:2];
        ratio     = {1'b0, st_reg.div_m1} + 4'h1;
        period_m1 = 4'((ratio << 1) - 4'h1);
        hi        = st_reg.active ? ratio : 4'h1;
        // synchronisers, first flop read only by second
        st_next.s_sync = {st_reg.s_sync[1:0], sync_i};
        st_next.s_pd   = {st_reg.s_pd[0], power_down_pin_i};
        st_next.s_oeb  = {st_reg.s_oeb[0], output_three_state_pin_i};
        sync_hit  = st_reg.s_sync[1] && !st_reg.s_sync[2] &&
                    st_reg.sync_en &&
                    (!st_reg.sync_once || st_reg.sync_armed);
        // ---------------------------------------------------------
        // wishbone slave
        // ---------------------------------------------------------
        st_next.ack   = acc;
        st_next.rdata = '0;
        if (acc && !wb_we_i) begin
            unique case (idx)
                adcoc_pkg::IDX_CHAN_SEL:
                    st_next.rdata[1:0] = st_reg.chan_sel;
                adcoc_pkg::IDX_POWER_MODE:
                    st_next.rdata[1:0] = st_reg.pmode;
                adcoc_pkg::IDX_CLOCK_CTRL:
                    st_next.rdata[0] = st_reg.retimer_en;
                adcoc_pkg::IDX_CLOCK_DIV:
                    st_next.rdata[2:0] = st_reg.div_m1;
                adcoc_pkg::IDX_OUTPUT_MODE: begin
                    st_next.rdata[1:0] = st_reg.fmt;
                    st_next.rdata[adcoc_pkg::OM_SPARE_BIT] = st_reg.om_spare;
                    st_next.rdata[adcoc_pkg::OM_DISABLE_BIT] =
                        st_reg.chan_sel[0] ? st_reg.dis[0] : st_reg.dis[1];
                end
                adcoc_pkg::IDX_DRIVE_CTRL:
                    st_next.rdata[0] = st_reg.reduced_drive;
                adcoc_pkg::IDX_SYNC_CTRL: begin
                    st_next.rdata[adcoc_pkg::SYNC_EN_BIT]   = st_reg.sync_en;
                    st_next.rdata[adcoc_pkg::SYNC_ONCE_BIT] = st_reg.sync_once;
                end
                adcoc_pkg::IDX_STATUS:
                    st_next.rdata[4:0] = {st_reg.sync_armed, st_reg.stby,
                        st_reg.pd, rate_low(st_reg.div_m1), st_reg.active};
                default: st_next.rdata = '0;
            endcase
        end
        if (wr) begin
            unique case (idx)
                adcoc_pkg::IDX_CHAN_SEL:
                    st_next.chan_sel = wb_dat_i[1:0];
                adcoc_pkg::IDX_POWER_MODE:
                    st_next.pmode = wb_dat_i[1:0];
                adcoc_pkg::IDX_CLOCK_CTRL: begin
                    st_next.retimer_en = wb_dat_i[0];
                    if (wb_dat_i[0] && !st_reg.retimer_en) begin
                        st_next.lock_cnt = adcoc_pkg::LOCK_W'(
                            adcoc_pkg::RELOCK_CYC);
                    end
                end
                adcoc_pkg::IDX_CLOCK_DIV: begin
                    st_next.div_m1 = wb_dat_i[2:0];
                    if (wb_dat_i[2:0] != st_reg.div_m1) begin
                        st_next.lock_cnt = adcoc_pkg::LOCK_W'(
                            adcoc_pkg::RELOCK_CYC);
                    end
                end
                adcoc_pkg::IDX_OUTPUT_MODE: begin
                    st_next.fmt = wb_dat_i[1:0];
                    st_next.om_spare = wb_dat_i[adcoc_pkg::OM_SPARE_BIT];
                    for (int c = 0; c < 2; c++) begin
                        if (st_reg.chan_sel[c]) begin
                            st_next.dis[c] =
                                wb_dat_i[adcoc_pkg::OM_DISABLE_BIT];
                        end
                    end
                end
                adcoc_pkg::IDX_DRIVE_CTRL:
                    st_next.reduced_drive = wb_dat_i[0];
                adcoc_pkg::IDX_SYNC_CTRL: begin
                    st_next.sync_en   = wb_dat_i[adcoc_pkg::SYNC_EN_BIT];
                    st_next.sync_once = wb_dat_i[adcoc_pkg::SYNC_ONCE_BIT];
                end
                default: st_next.chan_sel = st_reg.chan_sel;
            endcase
        end
        // ---------------------------------------------------------
        // sync arming and divider
        // ---------------------------------------------------------
        if (wr && idx == adcoc_pkg::IDX_SYNC_CTRL) begin
            st_next.sync_armed = 1'b1;
        end else if (sync_hit && st_reg.sync_once) begin
            st_next.sync_armed = 1'b0;
        end
        tick = (st_reg.cnt >= period_m1);
        if (sync_hit || tick) begin
            st_next.cnt = '0;
        end else begin
            st_next.cnt = st_reg.cnt + 4'h1;
        end
        // ---------------------------------------------------------
        // retimer lock
        // ---------------------------------------------------------
        if (st_reg.lock_cnt != '0 && st_next.lock_cnt == st_reg.lock_cnt) begin
            st_next.lock_cnt = st_reg.lock_cnt - 1'b1;
        end
        st_next.active = st_reg.retimer_en && (st_reg.lock_cnt == '0) &&
                         !rate_low(st_reg.div_m1);
        st_next.cclk = (st_next.cnt < hi);
        // ---------------------------------------------------------
        // sample pipeline
        // ---------------------------------------------------------
        if (tick && !sync_hit) begin
            st_next.held_b = st_reg.pipe_b[adcoc_pkg::LATENCY-1];
            st_next.pipe_a = {st_reg.pipe_a[adcoc_pkg::LATENCY-2:0],
                              clamp_s(ch_a_sample_i)};
            st_next.pipe_b = {st_reg.pipe_b[adcoc_pkg::LATENCY-2:0],
                              clamp_s(ch_b_sample_i)};
        end
        // ---------------------------------------------------------
        // power and output drivers
        // ---------------------------------------------------------
        pd_now = st_reg.s_pd[1] ||
                 (st_reg.pmode == adcoc_pkg::PM_DOWN);
        st_next.pd   = pd_now;
        st_next.stby = !pd_now &&
                       (st_reg.pmode == adcoc_pkg::PM_STANDBY);
        st_next.refp = !pd_now;
        st_next.oe = !pd_now && !st_reg.s_oeb[1] &&
                     (st_reg.dis != 2'h3);
        if (tick && !sync_hit) begin
            // rising phase carries channel a, or channel b when a is disabled
            if (st_reg.dis[0]) begin
                st_next.data = encode(st_reg.pipe_b[adcoc_pkg::LATENCY-1]
                    [adcoc_pkg::OUT_W-1:0], st_reg.fmt);
                st_next.ovr = st_reg.pipe_b[adcoc_pkg::LATENCY-1]
                    [adcoc_pkg::OUT_W];
            end else begin
                st_next.data = encode(st_reg.pipe_a[adcoc_pkg::LATENCY-1]
                    [adcoc_pkg::OUT_W-1:0], st_reg.fmt);
                st_next.ovr = st_reg.pipe_a[adcoc_pkg::LATENCY-1]
                    [adcoc_pkg::OUT_W];
            end
        end else if (st_next.cnt == hi && st_reg.cnt == hi - 4'h1) begin
            // falling phase carries channel b, or holds the rising-phase word when b is disabled
            if (st_reg.dis[1]) begin
                st_next.data = st_reg.data;
            end else begin
                st_next.data = encode(st_reg.held_b[adcoc_pkg::OUT_W-1:0],
                                      st_reg.fmt);
                st_next.ovr = st_reg.held_b[adcoc_pkg::OUT_W];
            end
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg            <= '0;
            st_reg.chan_sel   <= adcoc_pkg::CHAN_SEL_RST;
            st_reg.fmt        <= adcoc_pkg::FMT_RST;
            st_reg.om_spare   <= adcoc_pkg::OM_SPARE_RST;
            st_reg.retimer_en <= adcoc_pkg::RETIMER_EN_RST;
            st_reg.refp       <= 1'b1;
            st_reg.div_m1     <= adcoc_pkg::DIV_M1_RST;
            st_reg.lock_cnt   <= adcoc_pkg::LOCK_W'(adcoc_pkg::RELOCK_CYC);
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o            = st_reg.rdata;
    assign wb_ack_o            = st_reg.ack;
    assign data_o              = st_reg.data;
    assign data_oe_o           = st_reg.oe;
    assign overrange_o         = st_reg.ovr;
    assign capture_clock_out_o = st_reg.cclk;
    assign reduced_drive_o     = st_reg.reduced_drive;
    assign power_down_o        = st_reg.pd;
    assign standby_o           = st_reg.stby;
    assign ref_powered_o       = st_reg.refp;
    assign retimer_active_o    = st_reg.active;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_rise_active_div1;
        $rose(st_reg.cclk) && st_reg.active && hi == 4'h1 && !sync_hit;
    endsequence
    sequence seq_half_high;
        st_reg.cclk ##1 !st_reg.cclk;
    endsequence

    AST_DUTY_HALF: assert property (seq_rise_active_div1 |->
        seq_half_high) else $error("high time not half period");
    AST_RATE_LOW: assert property (st_reg.div_m1 != 3'h0 |=>
        !retimer_active_o) else $error("retimer active below rate");
    AST_BYPASS: assert property (st_reg.lock_cnt != '0 |=>
        !retimer_active_o) else $error("retimer active while unlocked");
    AST_PD_PIN: assert property ($rose(st_reg.s_pd[1]) |=>
        power_down_o && !ref_powered_o) else $error("pin did not power down");
    AST_PD_HIZ: assert property (power_down_o |->
        !data_oe_o) else $error("drivers on in power-down");
    AST_PD_EXIT: assert property (!st_reg.s_pd[1] &&
        st_reg.pmode == adcoc_pkg::PM_NORMAL |=> !power_down_o)
        else $error("no return from power-down");
    AST_OEB_PIN: assert property (st_reg.s_oeb[1] |=>
        !data_oe_o) else $error("drivers on with three-state pin high");
    AST_ONE_DIS: assert property (tick && !sync_hit && st_reg.dis[0] |=>
        data_o == encode($past(st_reg.pipe_b[adcoc_pkg::LATENCY-1]
        [adcoc_pkg::OUT_W-1:0]), $past(st_reg.fmt)))
        else $error("remaining channel not repeated");
    AST_CLAMP: assert property (tick && !sync_hit &&
        ch_a_sample_i > adcoc_pkg::FS_POS |=> st_reg.pipe_a[0] == 13'h17ff)
        else $error("overrange not clamped");
    AST_SYNC_RST: assert property (sync_hit |=>
        st_reg.cnt == 4'h0) else $error("divider not reset by strobe");
    AST_ONCE: assert property (sync_hit && st_reg.sync_once && !wr |=>
        !st_reg.sync_armed ##1 !sync_hit)
        else $error("single-shot sync rearmed");
endmodule

// *** dv/adcoc_capture.sv ***
// capture logic model at the far side of the converter outputs
// assumes data and overrange change together with capture_clock_out_i
`timescale 1ns/1ps
module adcoc_capture (
    input  wire logic        clk_i,
    input  wire logic        capture_clock_out_i,
    input  wire logic [11:0] data_i,
    input  wire logic        overrange_i,
    output logic      [11:0] word_a_o,
    output logic      [11:0] word_b_o,
    output logic             or_a_o
);
    // -------------------------------------------------------------
    // latch words on data clock phases
    // -------------------------------------------------------------
    logic cclk_reg;
    always @(posedge clk_i) begin
        cclk_reg <= capture_clock_out_i;
        if (capture_clock_out_i && !cclk_reg) begin
            word_a_o <= data_i;
            or_a_o   <= overrange_i;
        end
        if (!capture_clock_out_i && cclk_reg) begin
            word_b_o <= data_i;
        end
    end
endmodule

// *** dv/testbench.sv ***
// self-checking bench of the converter output control
// assumes the capture model and a 100 MHz clock
`timescale 1ns/1ps
module testbench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pd = 0, output_three_state_pin = 0;
    logic sy = 0;
    logic [9:0] adr = 0;
    logic [31:0] dat = 0, rd;
    logic signed [13:0] a_s = 0, b_s = 0;
    logic [31:0] wb_dat_o;
    logic [11:0] data_o, wa, wb_w;
    logic ack, oe, ovr, cclk, rdrv, pdo, sby, refp, rta, ora;
    int miscompares = 0, samples_checked = 0, cycles = 0, v;
    logic [7:0] q;
    always #5 clk_i = ~clk_i;
    adcoc_top i_adcoc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack),
        .ch_a_sample_i(a_s), .ch_b_sample_i(b_s), .power_down_pin_i(pd),
        .output_three_state_pin_i(output_three_state_pin), .sync_i(sy), .data_o(data_o),
        .data_oe_o(oe), .overrange_o(ovr), .capture_clock_out_o(cclk),
        .reduced_drive_o(rdrv), .power_down_o(pdo), .standby_o(sby),
        .ref_powered_o(refp), .retimer_active_o(rta));
    adcoc_capture i_adcoc_capture (.clk_i(clk_i), .capture_clock_out_i(cclk),
        .data_i(data_o), .overrange_i(ovr), .word_a_o(wa), .word_b_o(wb_w),
        .or_a_o(ora));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wbc(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00}; dat <= {24'h0, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = wb_dat_o[7:0];
        cyc <= 0; stb <= 0;
    endtask
    function automatic logic [11:0] fmt(int x, logic [1:0] f);
        logic [11:0] t, o;
        t = x > 2047 ? 12'h7ff : (x < -2048 ? 12'h800 : x[11:0]);
        o = t ^ 12'h800;
        return f == 2'h0 ? o : (f == 2'h2 ? o ^ (o >> 1) : t);
    endfunction
    task automatic cyc_n(input int n); repeat (n) @(posedge clk_i); endtask
    // one-cycle strobe; divider restarts so data clock is high then low
    task automatic pulse_sync();
        sy <= 1;
        cyc_n(1);
        sy <= 0;
        cyc_n(3);
        check(cclk, 1);
        cyc_n(1);
        check(cclk, 0);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict();
        end
    end
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    initial begin
        void'($urandom(28));
        cyc_n(6); rst_i <= 0;
        wbc(0, 8'h14, 0); check(q, 8'h05);
        wbc(0, 8'h30, 0); check(q, 0);
        check(rta, 0); cyc_n(200); check(rta, 1);
        $display("reset test done");
        for (int f = 0; f < 3; f++) begin
            v = $urandom_range(4095) - 2048;
            a_s <= v; b_s <= -v - 1; wbc(1, 8'h14, f); cyc_n(30);
            check(wa, fmt(v, f)); check(wb_w, fmt(-v - 1, f));
        end
        wbc(1, 8'h14, 1);
        for (int k = 0; k < 4; k++) begin
            v = k == 0 ? 2048 : k == 1 ? 2047 : k == 2 ? -2049 : -2048;
            a_s <= v; cyc_n(30);
            check(wa, fmt(v, 1)); check(ora, k % 2 == 0);
        end
        b_s <= -101;
        a_s <= 100; cyc_n(16); check(wa, fmt(-2048, 1));
        cyc_n(8); check(wa, fmt(100, 1));
        $display("format test done");
        pd <= 1; cyc_n(4); check(oe, 0); check(pdo, 1);
        pd <= 0; cyc_n(6); check(oe, 1); check(pdo, 0);
        output_three_state_pin <= 1; cyc_n(4); check(oe, 0); output_three_state_pin <= 0; cyc_n(4); check(oe, 1);
        wbc(1, 8'h08, 1); cyc_n(3); check(pdo, 1); check(oe, 0);
        wbc(1, 8'h08, 2); cyc_n(3); check({sby, refp}, 2'b11);
        wbc(1, 8'h08, 0); wbc(1, 8'h15, 1); cyc_n(3); check(rdrv, 1);
        $display("power test done");
        wbc(1, 8'h05, 1); wbc(1, 8'h14, 8'h11); cyc_n(30);
        check(wa, fmt(-101, 1)); check(wb_w, fmt(-101, 1));
        wbc(1, 8'h05, 3); wbc(1, 8'h14, 8'h11); cyc_n(4); check(oe, 0);
        wbc(1, 8'h0b, 1); cyc_n(10); check(rta, 0);
        $display("channel test done");
        wbc(1, 8'h3a, 8'h06); wbc(0, 8'h40, 0); check(q[4], 1);
        pulse_sync();
        wbc(0, 8'h40, 0); check(q[4], 0);
        wbc(1, 8'h3a, 8'h02);
        pulse_sync();
        cyc_n(1 + 4 * $urandom_range(3));
        pulse_sync();
        $display("sync test done");
        print_verdict();
    end
endmodule
